/* File: src/urx_pkg.sv */
// Package of constants and types for the UART receive channel
package urx_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [3:0] URX_ADDR_DATA   = 4'h0; // data_register
  localparam logic [3:0] URX_ADDR_STAT_A = 4'h4; // status_register_a
  localparam logic [3:0] URX_ADDR_CTRL_B = 4'h8; // control_register_b
  localparam logic [3:0] URX_ADDR_CTRL_C = 4'hc; // control_register_c

  // status_register_a bit positions
  localparam int URX_SA_PE   = 2; // parity_error_flag
  localparam int URX_SA_DOR  = 3; // overrun_flag
  localparam int URX_SA_FE   = 4; // frame_error_flag
  localparam int URX_SA_U2X  = 1; // double_speed
  localparam int URX_SA_RXC  = 7; // receive_complete_flag

  // control_register_b bit positions
  localparam int URX_CB_RECEIVED_NINTH_BIT = 1; // received_ninth_bit (read only)
  localparam int URX_CB_CSZ2 = 2; // char_size_field bit 2
  localparam int URX_CB_RECEIVER_ENABLE = 4; // receiver_enable
  localparam int URX_CB_RECEIVE_COMPLETE_IRQ_ENABLE = 7; // receive_complete_irq_enable

  // control_register_c bit positions
  localparam int URX_CC_CSZ0 = 1; // char_size_field bits 1:0
  localparam int URX_CC_SBS  = 3; // stop_bit_select (no effect on receive)
  localparam int URX_CC_PM0  = 4; // parity_mode_field bits 5:4
  localparam int URX_CC_SYNC = 6; // synchronous mode select

  // Reset values and the nine-bit size code
  localparam logic [7:0] URX_CTRL_B_RST = 8'h00;
  localparam logic [7:0] URX_CTRL_C_RST = 8'h06; // eight data bits
  localparam logic [2:0] URX_CSZ_NINE   = 3'h7;  // nine-bit characters

  // Oversampling figures and buffer depth
  localparam logic [3:0] URX_OVS_NORM_LAST = 4'hf; // 16 samples per bit
  localparam logic [3:0] URX_OVS_DBL_LAST  = 4'h7; // 8 samples per bit
  localparam logic [3:0] URX_VOTE_NORM     = 4'h7; // samples 8,9,10 at 7,8,9
  localparam logic [3:0] URX_VOTE_DBL      = 4'h3; // samples 4,5,6 at 3,4,5
  localparam int         URX_FIFO_DEPTH    = 2;    // two buffered characters

  // Receiver states
  typedef enum logic [1:0] {URX_IDLE, URX_START, URX_BITS} urx_state_t;

endpackage

/* File: src/urx_receiver.sv */
// UART receive channel: shift register, two-deep frame FIFO, status
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Enable bit turns receiver on, claims pin
// - Synchronous mode samples on transfer clock edges
// - Shift bits to first stop, ignore second
// - First stop moves frame into buffer
// - Unused upper data bits read zero
// - Ninth bit stored with frame, shown
// - Complete flag equals buffer non-empty
// - Disable drops reception, flushes buffer, clears flag
// - Disabled receiver releases the pin
// - Interrupt held while flag and enables set
// - Error flags buffered with their frame
// - Error flag writes ignored; software writes zero
// - Error flags never raise interrupts
// - Frame error follows first stop bit
// - Overrun: buffer full, shift full, new start
// - Overrun cleared on successful buffer store
// - Parity computed, compared, buffered when enabled
// - Parity flag only when checked, else zero
// - Sixteen or eight samples per bit
// - Start bit majority vote rejects noise
module urx_receiver
  import urx_pkg::*;
#(
  parameter int BAUD_DIV_W = 12 // Width of sample rate divisor
)
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Sample clock and global interrupt enable
  input  wire logic [BAUD_DIV_W-1:0] sample_div,
  input  wire logic                  global_irq_enable,
  // Serial pins
  input  wire logic                  serial_input_pin,
  input  wire logic                  transfer_clock_pin,
  // Pin ownership and interrupt
  output logic                       serial_input_claim,
  output logic                       rx_irq
);

  // One buffered frame: data, ninth bit, frame, overrun, parity errors
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       fe;
    logic       overrun_flag;
    logic       pe;
  } urx_entry_t;

  // Module state apart from the pin synchronisers
  typedef struct packed {
    urx_state_t             st;
    logic [BAUD_DIV_W-1:0]  div;      // sample tick divider
    logic [3:0]             smp;      // sample index within bit
    logic [2:0]             votes;    // center samples
    logic [3:0]             nbit;     // bits taken so far after start
    logic [9:0]             shf;      // data, ninth, parity
    logic                   held;     // complete frame waiting in shifter
    urx_entry_t             held_e;   // that frame's entry
    urx_entry_t [1:0]       fifo;     // receive buffer, slot 0 is head
    logic [1:0]             cnt;      // entries in buffer
    logic                   lost;     // overrun since last store
    logic [7:0]             ctrl_b;   // control_register_b writable bits
    logic [7:0]             ctrl_c;   // control_register_c
    logic                   u2x;      // double_speed
    logic [31:0]            rdata;    // registered read data
    logic                   ack;      // one-cycle answer
    logic                   xck_prev; // last synchronised transfer clock
  } urx_state_all_t;

  urx_state_all_t s_q;
  urx_state_all_t s_d;

  // Two-stage synchronisers for the pins
  logic [1:0] rxd_sync_q;
  logic [1:0] xck_sync_q;

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rxd_sync_q <= 2'h3;
      xck_sync_q <= 2'h0;
    end
    else
    begin
      rxd_sync_q <= {rxd_sync_q[0], serial_input_pin};
      xck_sync_q <= {xck_sync_q[0], transfer_clock_pin};
    end
  end

  // Decoded controls
  logic       rx_en;     // receiver_enable
  logic       sync_mode; // synchronous operation
  logic [2:0] csz;       // char_size_field
  logic       par_en;    // parity check enabled
  logic       par_odd;   // odd parity selected
  logic [3:0] nbits;     // data plus parity bits
  logic       rxd;       // synchronised line
  logic       xck_rise;  // transfer clock rising edge
  logic       tick;      // oversample enable pulse
  logic       rd_data;   // data_register read accepted this cycle
  logic       vote;      // majority of three samples

  assign rx_en     = s_q.ctrl_b[URX_CB_RECEIVER_ENABLE];
  assign sync_mode = s_q.ctrl_c[URX_CC_SYNC];
  assign csz       = {s_q.ctrl_b[URX_CB_CSZ2], s_q.ctrl_c[URX_CC_CSZ0+1 -: 2]};
  assign par_en    = s_q.ctrl_c[URX_CC_PM0+1];
  assign par_odd   = s_q.ctrl_c[URX_CC_PM0];
  assign rxd       = rxd_sync_q[1];
  assign xck_rise  = xck_sync_q[1] & ~s_q.xck_prev;
  assign tick      = (s_q.div == '0);
  assign rd_data   = avs_read & ~s_q.ack & (avs_address == URX_ADDR_DATA);
  assign vote      = (s_q.votes[0] & s_q.votes[1]) | (s_q.votes[0] & s_q.votes[2]) |
                     (s_q.votes[1] & s_q.votes[2]);

  // Data bit count for a char_size_field code
  function automatic logic [3:0] data_bits(input logic [2:0] c);
    if (c == URX_CSZ_NINE)
      data_bits = 4'h9;
    else if (c[2])
      data_bits = 4'h8; // reserved codes treated as eight bits
    else
      data_bits = 4'h5 + {2'h0, c[1:0]};
  endfunction

  assign nbits = data_bits(csz) + {3'h0, par_en};

  // Bus answer is registered: one wait cycle per access
  assign avs_waitrequest    = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata       = s_q.rdata;
  assign serial_input_claim = rx_en;
  assign rx_irq = s_q.ctrl_b[URX_CB_RECEIVE_COMPLETE_IRQ_ENABLE] & global_irq_enable & (s_q.cnt != 2'h0);

  // Next-state logic
  always_comb
  begin
    logic       bit_end;   // last sample of a bit
    logic [3:0] last;      // last sample index
    logic [3:0] vpos;      // first voting sample
    logic       take;      // one bit decided this cycle
    logic       bval;      // value of that bit
    logic       par_calc;  // computed parity
    logic [9:0] frame;     // shifter aligned to bit 0
    urx_entry_t e;         // entry being built
    s_d      = s_q;
    bit_end  = 1'b0;
    take     = 1'b0;
    bval     = 1'b0;
    par_calc = 1'b0;
    frame    = '0;
    e        = '0;
    last     = s_q.u2x ? URX_OVS_DBL_LAST : URX_OVS_NORM_LAST;
    vpos     = s_q.u2x ? URX_VOTE_DBL : URX_VOTE_NORM;
    s_d.xck_prev = xck_sync_q[1];
    s_d.ack      = 1'b0;

    s_d.div = tick ? sample_div : s_q.div - 1'b1;

    // Buffer pops on a data_register read
    if (rd_data && s_q.cnt != 2'h0)
    begin
      s_d.fifo[0] = s_q.fifo[1];
      s_d.cnt     = s_q.cnt - 1'b1;
    end

    // Shift-register frame moves in once there is room
    if (s_q.held && s_d.cnt != 2'(URX_FIFO_DEPTH))
    begin
      e = s_q.held_e;
      e.overrun_flag = s_q.lost;
      s_d.lost = 1'b0;
      s_d.fifo[s_d.cnt[0]] = e;
      s_d.cnt  = s_d.cnt + 1'b1;
      s_d.held = 1'b0;
    end

    // Receiver state machine
    case (s_q.st)
      URX_IDLE:
      begin
        if (sync_mode && xck_rise && !rxd)
        begin
          s_d.st = URX_BITS;
          s_d.nbit = '0;
        end
        else if (!sync_mode && tick && !rxd)
        begin
          s_d.st  = URX_START;
          s_d.smp = 4'h1;
        end
      end
      URX_START:
      begin
        if (tick)
        begin
          s_d.smp = s_q.smp + 1'b1;
          if (s_q.smp >= vpos && s_q.smp <= vpos + 4'h2)
            s_d.votes = {s_q.votes[1:0], rxd};
          if (s_q.smp == vpos + 4'h3)
          begin
            if (vote)
              s_d.st = URX_IDLE;
          end
          if (s_q.smp == last && !vote)
          begin
            s_d.st   = URX_BITS;
            s_d.smp  = '0;
            s_d.nbit = '0;
          end
        end
      end
      URX_BITS:
      begin
        if (sync_mode)
        begin
          take = xck_rise;
          bval = rxd;
        end
        else if (tick)
        begin
          s_d.smp = s_q.smp + 1'b1;
          if (s_q.smp >= vpos && s_q.smp <= vpos + 4'h2)
            s_d.votes = {s_q.votes[1:0], rxd};
          bit_end = (s_q.smp == last);
          // Decide right after the center samples so next start is early
          take = (s_q.smp == vpos + 4'h3);
          bval = vote;
        end
        if (take)
        begin
          if (s_q.nbit < nbits)
          begin
            s_d.shf  = {bval, s_q.shf[9:1]};
            s_d.nbit = s_q.nbit + 1'b1;
          end
          else
          begin
            // First stop bit ends frame, later stops ignored
            s_d.st = URX_IDLE;
            frame  = s_q.shf >> (4'ha - nbits);
            par_calc = ^(frame[8:0] & 9'((10'h1 << data_bits(csz)) - 10'h1)) ^ par_odd;
            e.data  = frame[7:0] & 8'((9'h1 << data_bits(csz)) - 9'h1);
            e.ninth = (csz == URX_CSZ_NINE) & frame[8];
            e.fe    = ~bval;
            e.pe    = par_en & (par_calc != frame[data_bits(csz)]);
            // Frame goes to buffer or waits in shifter
            s_d.held   = 1'b1;
            s_d.held_e = e;
          end
        end
        if (bit_end)
          s_d.smp = '0;
      end
      default: s_d.st = URX_IDLE;
    endcase

    // Overrun when full buffer, held frame, new start
    if (s_q.st == URX_IDLE && s_d.st != URX_IDLE && s_q.held && s_q.cnt == 2'(URX_FIFO_DEPTH))
    begin
      s_d.lost = 1'b1;
      s_d.held = 1'b0;
    end

    // Register reads, answered one cycle after the request
    if (avs_read && !s_q.ack)
    begin
      s_d.ack   = 1'b1;
      s_d.rdata = '0;
      if (avs_address == URX_ADDR_DATA)
        s_d.rdata[7:0] = s_q.fifo[0].data;
      else if (avs_address == URX_ADDR_STAT_A)
      begin
        // Parity flag zero when checking off
        s_d.rdata[URX_SA_RXC] = (s_q.cnt != 2'h0);
        s_d.rdata[URX_SA_FE]  = s_q.fifo[0].fe & (s_q.cnt != 2'h0);
        s_d.rdata[URX_SA_DOR] = s_q.fifo[0].overrun_flag & (s_q.cnt != 2'h0);
        s_d.rdata[URX_SA_PE]  = s_q.fifo[0].pe & par_en & (s_q.cnt != 2'h0);
        s_d.rdata[URX_SA_U2X] = s_q.u2x;
      end
      else if (avs_address == URX_ADDR_CTRL_B)
      begin
        s_d.rdata[7:0]         = s_q.ctrl_b;
        s_d.rdata[URX_CB_RECEIVED_NINTH_BIT] = s_q.fifo[0].ninth & (s_q.cnt != 2'h0);
      end
      else if (avs_address == URX_ADDR_CTRL_C)
        s_d.rdata[7:0] = s_q.ctrl_c;
    end

    // Register writes; unmapped addresses are accepted and ignored
    if (avs_write && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      // Only double_speed is writable in status
      if (avs_address == URX_ADDR_STAT_A)
        s_d.u2x = avs_writedata[URX_SA_U2X];
      else if (avs_address == URX_ADDR_CTRL_B)
        s_d.ctrl_b = avs_writedata[7:0] & ~(8'h1 << URX_CB_RECEIVED_NINTH_BIT);
      else if (avs_address == URX_ADDR_CTRL_C)
        s_d.ctrl_c = avs_writedata[7:0];
    end

    // Disabled receiver idles, flushes, drops frame
    if (!rx_en)
    begin
      s_d.st   = URX_IDLE;
      s_d.cnt  = '0;
      s_d.held = 1'b0;
      s_d.lost = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_q        <= '0;
      s_q.ctrl_b <= URX_CTRL_B_RST;
      s_q.ctrl_c <= URX_CTRL_C_RST;
      s_q.st     <= URX_IDLE;
    end
    else
      s_q <= s_d;
  end

  a_rxc_matches_fifo: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (avs_read && !s_q.ack && avs_address == URX_ADDR_STAT_A) |=>
    (avs_readdata[URX_SA_RXC] == ($past(s_q.cnt) != 2'h0)))
    else $error("complete flag disagrees with buffer");

  a_disable_flush: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rx_en |=> (s_q.cnt == 2'h0 && !s_q.held && s_q.st == URX_IDLE))
    else $error("buffer not flushed on disable");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_q.cnt == 2'h0) |-> !rx_irq)
    else $error("interrupt without unread data");

  a_err_no_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!s_q.ctrl_b[URX_CB_RECEIVE_COMPLETE_IRQ_ENABLE] && $changed(s_q.fifo)) |-> !rx_irq)
    else $error("interrupt from error flags");

  a_pin_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (serial_input_claim == rx_en))
    else $error("pin ownership wrong");

  a_pe_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (avs_read && !s_q.ack && avs_address == URX_ADDR_STAT_A && !par_en) |=> !avs_readdata[URX_SA_PE])
    else $error("parity flag set while checking off");

  a_overrun_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(s_q.lost) |-> $past(s_q.cnt) == 2'(URX_FIFO_DEPTH) && $past(s_q.held))
    else $error("overrun without full buffer");

  a_frame_stored: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($rose(s_q.held) && s_q.cnt < 2'(URX_FIFO_DEPTH) && rx_en && !rd_data) |=> (!s_q.held || !rx_en))
    else $error("frame not moved to buffer");

  a_err_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (avs_write && !s_q.ack && avs_address == URX_ADDR_STAT_A) |=> $stable(s_q.fifo) || $past(s_q.held))
    else $error("status write altered error flags");

endmodule

/* File: verification/tb.sv */
// Self-checking bench for the UART receive channel
`timescale 1ns/1ps
module tb;
  import urx_pkg::*;

  // Bus and pin signals
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        global_irq_enable = 1'b0;
  logic        line, xck, busy, claim, rx_irq;
  // Model control
  logic        go = 1'b0;
  logic        sync_mode = 1'b0;
  logic [11:0] bits = 12'h000;
  logic [3:0]  nbits = 4'h0;
  logic [7:0]  bclk = 8'h10;
  // Bookkeeping
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] q;

  // Sample tick every clock, so 16 clocks per bit
  urx_receiver i_urx_receiver (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_div(12'h000),
    .global_irq_enable(global_irq_enable), .serial_input_pin(line), .transfer_clock_pin(xck),
    .serial_input_claim(claim), .rx_irq(rx_irq));

  urx_line_model i_urx_line_model (.sys_clk(sys_clk), .go(go), .sync_mode(sync_mode), .bits(bits),
    .nbits(nbits), .bit_clks(bclk), .line(line), .xck(xck), .busy(busy));

  // Clock
  initial
    forever #5 sys_clk = ~sys_clk;

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
    end
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Pin comparison, sampled mid-cycle where outputs are settled
  task automatic chk_pin(input logic got_sel, input logic exp, input string what);
    @(negedge sys_clk);
    chk({31'h0, got_sel ? rx_irq : claim}, {31'h0, exp}, what);
    // Back on the rising edge so the next stimulus change lands there
    @(posedge sys_clk);
  endtask

  // One Avalon-MM access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, d};
    // Waitrequest and read data are taken at the same rising edge
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // Read and compare the masked byte
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
    bus(1'b0, a, 8'h00);
    chk(q & {24'h0, m}, {24'h0, e}, what);
  endtask

  // Hand a frame to the model; wt waits for the line to go idle
  task automatic launch(input logic [11:0] f, input logic [3:0] n, input logic wt);
    @(posedge sys_clk);
    bits  <= f;
    nbits <= n;
    go    <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    if (wt)
    begin
      do @(posedge sys_clk); while (busy !== 1'b0);
      repeat (4) @(posedge sys_clk);
    end
  endtask

  // Build data, optional parity of sense podd, first stop stopv, second stop high
  task automatic send(input logic [8:0] d, input int nd, input logic pen, input logic podd,
                      input logic stopv, input logic wt);
    logic [11:0] f;
    int          n;
    f = 12'h000;
    for (int i = 0; i < nd; i++)
      f[i] = d[i];
    f[nd] = podd ^ (^(d & 9'((1 << nd) - 1)));
    n = nd + int'(pen);
    f[n] = stopv;
    f[n+1] = 1'b1;
    launch(f, 4'(n + 2), wt);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // Test sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(URX_ADDR_CTRL_C, 8'hff, 8'h06, "ctrl_c reset");
    rd(URX_ADDR_CTRL_B, 8'hff, 8'h00, "ctrl_b reset");
    rd(4'h2, 8'hff, 8'h00, "unmapped read");
    chk_pin(1'b0, 1'b0, "claim off");
    wr(URX_ADDR_CTRL_C, 8'h0e);
    wr(URX_ADDR_CTRL_B, 8'h10);
    chk_pin(1'b0, 1'b1, "claim on");
    send(9'h05a, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h80, "status one frame");
    rd(URX_ADDR_DATA, 8'hff, 8'h5a, "data plain");
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h00, "status empty");
    send(9'h033, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h90, "frame error");
    rd(URX_ADDR_DATA, 8'hff, 8'h33, "data frame error");
    tend("basic");
    wr(URX_ADDR_CTRL_C, 8'h00);
    send(9'h1ff, 5, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_DATA, 8'hff, 8'h1f, "five bit data");
    wr(URX_ADDR_CTRL_C, 8'h26);
    send(9'h03c, 8, 1'b1, 1'b0, 1'b1, 1'b1);
    send(9'h03c, 8, 1'b1, 1'b1, 1'b1, 1'b1);
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h80, "even parity good");
    rd(URX_ADDR_DATA, 8'hff, 8'h3c, "even data");
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h84, "even parity bad");
    rd(URX_ADDR_DATA, 8'hff, 8'h3c, "even data bad");
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h00, "parity flag cleared");
    wr(URX_ADDR_CTRL_C, 8'h36);
    send(9'h007, 8, 1'b1, 1'b1, 1'b1, 1'b1);
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h84 & 8'h80, "odd parity good");
    rd(URX_ADDR_DATA, 8'hff, 8'h07, "odd data");
    tend("format");
    wr(URX_ADDR_CTRL_C, 8'h06);
    wr(URX_ADDR_STAT_A, 8'h1e);
    rd(URX_ADDR_STAT_A, 8'h9e, 8'h02, "flag writes ignored");
    bclk <= 8'h08;
    send(9'h081, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_DATA, 8'hff, 8'h81, "double speed data");
    wr(URX_ADDR_STAT_A, 8'h00);
    bclk <= 8'h04;
    launch(12'h000, 4'h0, 1'b1);
    bclk <= 8'h10;
    rd(URX_ADDR_STAT_A, 8'h80, 8'h00, "glitch rejected");
    tend("sampling");
    wr(URX_ADDR_CTRL_B, 8'h14);
    send(9'h1a5, 9, 1'b0, 1'b0, 1'b1, 1'b1);
    send(9'h05a, 9, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_CTRL_B, 8'h02, 8'h02, "ninth bit one");
    rd(URX_ADDR_DATA, 8'hff, 8'ha5, "nine bit low");
    rd(URX_ADDR_CTRL_B, 8'h02, 8'h00, "ninth bit zero");
    rd(URX_ADDR_DATA, 8'hff, 8'h5a, "nine bit low two");
    wr(URX_ADDR_CTRL_B, 8'h10);
    tend("nine bit");
    for (int k = 1; k <= 4; k++)
      send(9'(k * 17), 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h80, "first kept");
    rd(URX_ADDR_DATA, 8'hff, 8'h11, "first data");
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h80, "second kept");
    rd(URX_ADDR_DATA, 8'hff, 8'h22, "second data");
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h88, "overrun flagged");
    rd(URX_ADDR_DATA, 8'hff, 8'h44, "data after loss");
    send(9'h055, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_STAT_A, 8'h9c, 8'h80, "overrun cleared");
    rd(URX_ADDR_DATA, 8'hff, 8'h55, "clean data");
    tend("overrun");
    global_irq_enable <= 1'b1;
    send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_pin(1'b1, 1'b0, "no error irq");
    rd(URX_ADDR_DATA, 8'hff, 8'h66, "error frame data");
    wr(URX_ADDR_CTRL_B, 8'h90);
    send(9'h067, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    chk_pin(1'b1, 1'b1, "irq on");
    global_irq_enable <= 1'b0;
    chk_pin(1'b1, 1'b0, "irq gated");
    global_irq_enable <= 1'b1;
    chk_pin(1'b1, 1'b1, "irq held");
    rd(URX_ADDR_DATA, 8'hff, 8'h67, "irq data");
    chk_pin(1'b1, 1'b0, "irq cleared");
    tend("interrupt");
    send(9'h077, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    send(9'h078, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    repeat (60) @(posedge sys_clk);
    wr(URX_ADDR_CTRL_B, 8'h00);
    chk_pin(1'b0, 1'b0, "claim released");
    rd(URX_ADDR_STAT_A, 8'h80, 8'h00, "flushed");
    do @(posedge sys_clk); while (busy !== 1'b0);
    wr(URX_ADDR_CTRL_B, 8'h10);
    rd(URX_ADDR_STAT_A, 8'h80, 8'h00, "partial dropped");
    send(9'h079, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_DATA, 8'hff, 8'h79, "after re-enable");
    rd(URX_ADDR_STAT_A, 8'h80, 8'h00, "empty again");
    tend("disable");
    wr(URX_ADDR_CTRL_C, 8'h46);
    sync_mode <= 1'b1;
    send(9'h0c3, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(URX_ADDR_DATA, 8'hff, 8'hc3, "sync data");
    tend("sync");
    end_sim();
  end
endmodule

/* File: verification/urx_line_model.sv */
// Remote serial transmitter model for the receive line
`timescale 1ns/1ps
module urx_line_model
(
  // Clock
  input  wire logic        sys_clk,
  // Frame request from the bench
  input  wire logic        go,
  input  wire logic        sync_mode,
  input  wire logic [11:0] bits,
  input  wire logic [3:0]  nbits,
  input  wire logic [7:0]  bit_clks,
  // Line side
  output logic             line,
  output logic             xck,
  output logic             busy
);
  logic [11:0] f; // Latched frame bits
  int          n; // Latched bit count

  // Idle line is high, as with a pull-up
  initial
  begin
    line = 1'b1;
    xck  = 1'b0;
    busy = 1'b0;
  end

  // Start bit, then frame bits LSB first, each bit_clks long
  always
  begin
    @(posedge sys_clk);
    if (go)
    begin
      f = bits;
      n = nbits;
      busy <= 1'b1;
      for (int i = 0; i <= n; i++)
        for (int c = 0; c < bit_clks; c++)
        begin
          line <= (i == 0) ? 1'b0 : f[i-1];
          // Transfer clock only inside a frame, rising mid-bit so data is settled
          xck  <= sync_mode && (c >= bit_clks / 2);
          @(posedge sys_clk);
        end
      line <= 1'b1;
      xck  <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule
